// ==== rtl/buck_prot_pkg.sv ====
// Constants and carrier types for buck protection and gate sequencing
package buck_prot_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned OVERLAP_TIMEOUT_NS = 250;
   // Longest wait rounds down, at least one cycle
   localparam int unsigned OVERLAP_TIMEOUT_RAW = (OVERLAP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned OVERLAP_TIMEOUT_CYC =
      (OVERLAP_TIMEOUT_RAW < 1) ? 1 : OVERLAP_TIMEOUT_RAW;
   localparam int unsigned TIMEOUT_W = 4;
   // Synchroniser latency plus one gate update before flags are trusted
   localparam int unsigned FLAG_SETTLE_CYC = 5;

   // ----------------------------------------
   // Voltage code decode, units of 0.1 mV
   // ----------------------------------------
   localparam int unsigned CODE_W = 7;
   localparam int unsigned TARGET_W = 14;
   localparam logic [TARGET_W-1:0] TARGET_TOP = 14'h3a98;
   localparam logic [TARGET_W-1:0] TARGET_STEP = 14'h007d;
   localparam logic [TARGET_W-1:0] TARGET_ZERO = 14'h0000;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic GATE_OFF = 1'h0;
   localparam logic FLAG_CLR = 1'h0;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   // Pin and comparator flags, all asynchronous to clk_in
   typedef struct packed {
      logic enable;              // Enable pin
      logic supply_ok;           // Supply above supply_ok_threshold
      logic supply_uvlo;         // Supply below supply_undervoltage_threshold
      logic overvoltage;         // Output above overvoltage_protect threshold
      logic sense_below_enter;   // output_sense_ref below -300 mV
      logic sense_above_exit;    // output_sense_ref above -100 mV
      logic switch_node_low;     // switch_node below 2.2 V
      logic high_gate_low;       // high_side_gate below 2.2 V
      logic low_gate_low;        // low_side_gate below 2.2 V
      logic pg_window;           // Output inside power-good window
      logic [CODE_W-1:0] voltage_code;
   } sense_pins_t;

   typedef struct packed {
      logic high_side_gate;
      logic low_side_gate;
   } gate_drive_t;

endpackage : buck_prot_pkg

// ==== rtl/flag_sync.sv ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module flag_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Asynchronous inputs
   input wire logic [W-1:0] async_in,
   // Synchronised outputs
   output logic [W-1:0] sync_out
);

   logic [W-1:0] stage1_r;
   logic [W-1:0] stage2_r;
   logic [W-1:0] stage3_r;
   logic [W-1:0] held_r;

   // ----------------------------------------
   // Synchroniser chain
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         stage1_r <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
      end
      else
      begin
         stage1_r <= async_in;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // ----------------------------------------
   // Accept a bit once stages two and three agree
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         held_r <= '0;
      else
      begin
         for (int i = 0; i < W; i++)
         begin
            if (stage2_r[i] == stage3_r[i])
               held_r[i] <= stage3_r[i];
         end
      end
   end

   assign sync_out = held_r;

endmodule : flag_sync

// ==== rtl/buck_protection_gate_sequencer.sv ====
// Protection, enable gating and adaptive dead-time gate sequencer
`timescale 1ns/1ps
module buck_protection_gate_sequencer
   import buck_prot_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = OVERLAP_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Internal modulation, same clock domain
   input wire logic pwm_in,
   // Pins and comparator flags
   input wire buck_prot_pkg::sense_pins_t pins_in,
   // Gate drive
   output buck_prot_pkg::gate_drive_t gate_drive_out,
   // Open-drain power-good
   output logic power_good_out,
   output logic power_good_oe_n_out,
   // Decoded target, 0.1 mV units
   output logic [buck_prot_pkg::TARGET_W-1:0] target_out,
   // Status
   output logic latched_off_out,
   output logic reverse_protect_out
);
   import buck_prot_pkg::*;

   typedef enum logic [1:0] {
      PWR_SHUTDOWN,
      PWR_RUN,
      PWR_LATCHED
   } power_state_t;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_HIGH_ON,
      SEQ_WAIT_LOW,
      SEQ_LOW_ON,
      SEQ_WAIT_HIGH
   } seq_state_t;

   sense_pins_t pins_s;
   power_state_t pwr_r;
   power_state_t pwr_nxt;
   seq_state_t seq_r;
   seq_state_t seq_nxt;
   logic reverse_protect_r;
   logic [TIMEOUT_W-1:0] timeout_cnt_r;
   logic timeout_hit;
   logic flags_settled;
   gate_drive_t gate_nxt;
   gate_drive_t gate_r;
   logic power_good_r;
   logic [TARGET_W-1:0] target_r;

   // ----------------------------------------
   // Voltage code decode
   // ----------------------------------------
   function automatic logic [TARGET_W-1:0] decode_code(input logic [CODE_W-1:0] code);
      logic [TARGET_W+CODE_W-1:0] drop;
      drop = TARGET_STEP * code;
      if (drop >= {{CODE_W{1'b0}}, TARGET_TOP})
         decode_code = TARGET_ZERO;
      else
         decode_code = TARGET_TOP - drop[TARGET_W-1:0];
   endfunction : decode_code

   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   // synchronise comparator flags
   flag_sync #(
      .W($bits(sense_pins_t))
   ) u_pin_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(pins_in),
      .sync_out(pins_s)
   );

   // ----------------------------------------
   // Power state
   // ----------------------------------------
   always_comb
   begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         PWR_SHUTDOWN:
            // start on supply ok and enable
            if (pins_s.enable && pins_s.supply_ok && !pins_s.supply_uvlo)
               pwr_nxt = PWR_RUN;
         PWR_RUN:
            // stop on undervoltage or enable low
            if (!pins_s.enable || pins_s.supply_uvlo)
               pwr_nxt = PWR_SHUTDOWN;
            else if (pins_s.overvoltage)
               pwr_nxt = PWR_LATCHED;
         PWR_LATCHED:
            // clear by enable low or supply loss
            if (!pins_s.enable || pins_s.supply_uvlo)
               pwr_nxt = PWR_SHUTDOWN;
         default:
            pwr_nxt = PWR_SHUTDOWN;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         pwr_r <= PWR_SHUTDOWN;
      else
         pwr_r <= pwr_nxt;
   end

   // ----------------------------------------
   // Reverse voltage protection
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         reverse_protect_r <= FLAG_CLR;
      // enter below -300 mV, entry wins
      else if (pins_s.sense_below_enter)
         reverse_protect_r <= 1'b1;
      else if (pins_s.sense_above_exit)
         reverse_protect_r <= FLAG_CLR;
   end

   // ----------------------------------------
   // Dead-time sequencer
   // ----------------------------------------
   assign timeout_hit = (timeout_cnt_r >= TIMEOUT_W'(TIMEOUT_CYC - 1));
   assign flags_settled = (timeout_cnt_r >= TIMEOUT_W'(FLAG_SETTLE_CYC));

   always_comb
   begin
      seq_nxt = seq_r;
      case (seq_r)
         SEQ_IDLE:
            if (pwm_in)
               seq_nxt = SEQ_WAIT_HIGH;
            else
               seq_nxt = SEQ_WAIT_LOW;
         SEQ_HIGH_ON:
            // modulation fall turns high side off
            if (!pwm_in)
               seq_nxt = SEQ_WAIT_LOW;
         SEQ_WAIT_LOW:
            if (pwm_in)
               seq_nxt = SEQ_WAIT_HIGH;
            // wait for switch node and high gate
            else if (flags_settled && pins_s.switch_node_low && pins_s.high_gate_low)
               seq_nxt = SEQ_LOW_ON;
            else if (timeout_hit)
               seq_nxt = SEQ_LOW_ON;
         SEQ_LOW_ON:
            // modulation rise turns low side off
            if (pwm_in)
               seq_nxt = SEQ_WAIT_HIGH;
         SEQ_WAIT_HIGH:
            if (!pwm_in)
               seq_nxt = SEQ_WAIT_LOW;
            // wait for low gate below threshold
            else if (flags_settled && pins_s.low_gate_low)
               seq_nxt = SEQ_HIGH_ON;
         default:
            seq_nxt = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         seq_r <= SEQ_IDLE;
      else if (pwr_r != PWR_RUN || reverse_protect_r)
         seq_r <= SEQ_IDLE;
      else
         seq_r <= seq_nxt;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         timeout_cnt_r <= '0;
      else if (seq_nxt != seq_r || (seq_r != SEQ_WAIT_LOW && seq_r != SEQ_WAIT_HIGH))
         timeout_cnt_r <= '0;
      else if (timeout_cnt_r != '1)
         timeout_cnt_r <= timeout_cnt_r + TIMEOUT_W'(1);
   end

   // ----------------------------------------
   // Gate drive selection
   // ----------------------------------------
   always_comb
   begin
      gate_nxt.high_side_gate = GATE_OFF;
      gate_nxt.low_side_gate = GATE_OFF;
      case (pwr_r)
         PWR_RUN:
            if (!reverse_protect_r)
            begin
               // gates decoded from one state only
               gate_nxt.high_side_gate = (seq_r == SEQ_HIGH_ON);
               gate_nxt.low_side_gate = (seq_r == SEQ_LOW_ON);
            end
         PWR_LATCHED:
            gate_nxt.low_side_gate = !reverse_protect_r;
         PWR_SHUTDOWN:
            gate_nxt.low_side_gate = GATE_OFF;
         default:
            gate_nxt.low_side_gate = GATE_OFF;
      endcase
      // overvoltage in run acts at once
      if (pwr_r == PWR_RUN && pins_s.overvoltage)
      begin
         gate_nxt.high_side_gate = GATE_OFF;
         gate_nxt.low_side_gate = !reverse_protect_r;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         gate_r <= '0;
      else
         gate_r <= gate_nxt;
   end

   // ----------------------------------------
   // Power-good and voltage target
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         power_good_r <= FLAG_CLR;
      else
         power_good_r <= (pwr_r == PWR_RUN) && pins_s.pg_window && !reverse_protect_r;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         target_r <= TARGET_TOP;
      else
         target_r <= decode_code(pins_s.voltage_code);
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign gate_drive_out = gate_r;
   assign power_good_out = power_good_r;
   assign power_good_oe_n_out = power_good_r;
   assign target_out = target_r;
   assign latched_off_out = (pwr_r == PWR_LATCHED);
   assign reverse_protect_out = reverse_protect_r;

endmodule : buck_protection_gate_sequencer

// ==== verif/prot_checker_asserts.sv ====
// Port checks for the gate sequencer
`timescale 1ns/1ps
module prot_checker
   import buck_prot_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = 10
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Inputs
   input wire logic pwm_in,
   input wire buck_prot_pkg::sense_pins_t pins_in,
   // Outputs
   input wire buck_prot_pkg::gate_drive_t gate_drive_out,
   input wire logic power_good_out,
   input wire logic power_good_oe_n_out,
   input wire logic [buck_prot_pkg::TARGET_W-1:0] target_out,
   input wire logic latched_off_out,
   input wire logic reverse_protect_out
);
   localparam int TO_MAX = TIMEOUT_CYC + 3;
   logic hs;
   logic ls;
   assign hs = gate_drive_out.high_side_gate;
   assign ls = gate_drive_out.low_side_gate;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   a_no_overlap: assert property (!(hs && ls))
      else $error("both gates on");
   a_crowbar_on: assert property (latched_off_out && $past(latched_off_out)
      && !reverse_protect_out && !$past(reverse_protect_out) |-> ls && !hs)
      else $error("no crowbar in latch-off");
   a_latch_hold: assert property ((latched_off_out && pins_in.enable
      && !pins_in.supply_uvlo) [*6] |=> latched_off_out)
      else $error("latch-off cleared early");
   a_reverse_off: assert property (reverse_protect_out && $past(reverse_protect_out)
      |-> !(hs || ls))
      else $error("gate on in reverse protection");
   a_reverse_exit: assert property ($fell(reverse_protect_out)
      |-> $past(pins_in.sense_above_exit, 4))
      else $error("reverse protection ended early");
   a_shutdown_low: assert property (!pins_in.enable [*8]
      |-> !(hs || ls || power_good_out))
      else $error("output active in shutdown");
   a_pg_pin: assert property (power_good_oe_n_out == power_good_out)
      else $error("power-good pin mismatch");
   a_low_wait: assert property ($rose(ls) && !latched_off_out
      |-> !$past(hs) && !$past(hs, 2))
      else $error("low gate on too soon");
   a_low_timeout: assert property ($fell(hs) && !pwm_in && pins_in.enable
      && !latched_off_out && !reverse_protect_out |-> ##[1:TO_MAX] (ls || pwm_in
      || !pins_in.enable || pins_in.supply_uvlo || latched_off_out || reverse_protect_out))
      else $error("low gate timeout missed");
   a_high_wait: assert property ($rose(hs)
      |-> !$past(ls) && !$past(ls, 2) && !$past(ls, 3))
      else $error("high gate on too soon");
endmodule : prot_checker

bind buck_protection_gate_sequencer prot_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
   .clk_in, .sys_rst_in, .pwm_in, .pins_in, .gate_drive_out, .power_good_out,
   .power_good_oe_n_out, .target_out, .latched_off_out, .reverse_protect_out);

// ==== verif/power_stage_model.sv ====
// Power stage model giving below-threshold flags
`timescale 1ns/1ps
module power_stage_model
   import buck_prot_pkg::*;
(
   // Clock and control
   input wire logic clk_in,
   input wire logic stall_in,
   // Gate drive
   input wire buck_prot_pkg::gate_drive_t gate_in,
   // Switch node, high gate, low gate below 2.2 V
   output logic [2:0] low_flags_out
);
   logic hs_r = 1'h0;
   logic ls_r = 1'h0;
   always_ff @(posedge clk_in)
   begin
      hs_r <= gate_in.high_side_gate;
      ls_r <= gate_in.low_side_gate;
   end
   // Gates discharge one cycle after release; stall holds switch node up
   assign low_flags_out[1] = !hs_r && !gate_in.high_side_gate;
   assign low_flags_out[2] = low_flags_out[1] && !stall_in;
   assign low_flags_out[0] = !ls_r && !gate_in.low_side_gate;
endmodule : power_stage_model

// ==== verif/tb_buck_protection_gate_sequencer.sv ====
// Self-checking bench for the gate sequencer
`timescale 1ns/1ps
module tb_buck_protection_gate_sequencer;
   import buck_prot_pkg::*;
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [TARGET_W-1:0] target;
   } row_t;
   logic clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic pwm_in = 1'h0;
   logic stall = 1'h0;
   sense_pins_t drv;
   sense_pins_t pins;
   logic [2:0] flags;
   gate_drive_t gate;
   logic pg;
   logic pg_oe_n;
   logic [TARGET_W-1:0] target;
   logic latched;
   logic rev;
   int num_errors = 0;
   int n_tests = 0;
   row_t rows [8] = '{'{7'h00, 14'h3a98}, '{7'h01, 14'h3a1b}, '{7'h1f, 14'h2b75},
      '{7'h20, 14'h2af8}, '{7'h40, 14'h1b58}, '{7'h77, 14'h007d},
      '{7'h78, 14'h0000}, '{7'h7f, 14'h0000}};
   always #12.5 clk_in = ~clk_in;
   assign pins = {drv[16:11], flags, drv[7:0]};
   buck_protection_gate_sequencer dut (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pwm_in(pwm_in),
      .pins_in(pins),
      .gate_drive_out(gate),
      .power_good_out(pg),
      .power_good_oe_n_out(pg_oe_n),
      .target_out(target),
      .latched_off_out(latched),
      .reverse_protect_out(rev)
   );
   power_stage_model stage (
      .clk_in(clk_in),
      .stall_in(stall),
      .gate_in(gate),
      .low_flags_out(flags)
   );
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // Wait, then compare high, low, power-good, latch, reverse
   task automatic step(input int n, input logic [4:0] exp);
      repeat (n) @(negedge clk_in);
      n_tests++;
      if ({gate, pg, latched, rev} !== exp || pg_oe_n !== exp[2])
      begin
         num_errors++;
         $display("BAD %0t state %b oe_n %b exp %b", $time, {gate, pg, latched, rev}, pg_oe_n,
            exp);
      end
   endtask : step
   initial
   begin
      repeat (3000) @(posedge clk_in);
      num_errors++;
      finish_test();
   end
   initial
   begin
      drv = '0;
      drv.sense_above_exit = 1'h1;
      repeat (5) @(negedge clk_in);
      sys_rst_in = 1'h0;
      step(1, 5'b00000);
      foreach (rows[i])
      begin
         drv.voltage_code = rows[i].code;
         repeat (7) @(negedge clk_in);
         n_tests++;
         if (target !== rows[i].target)
         begin
            num_errors++;
            $display("BAD %0t target %h code %h", $time, target, rows[i].code);
         end
      end
      $display("decode done");
      drv.enable = 1'h1;
      drv.supply_ok = 1'h1;
      drv.pg_window = 1'h1;
      pwm_in = 1'h1;
      step(14, 5'b10100);
      pwm_in = 1'h0;
      step(12, 5'b01100);
      pwm_in = 1'h1;
      step(3, 5'b00100);
      step(9, 5'b10100);
      stall = 1'h1;
      pwm_in = 1'h0;
      step(11, 5'b00100);
      step(3, 5'b01100);
      stall = 1'h0;
      pwm_in = 1'h1;
      step(12, 5'b10100);
      $display("sequencing done");
      drv.sense_below_enter = 1'h1;
      drv.sense_above_exit = 1'h0;
      step(8, 5'b00001);
      drv.sense_below_enter = 1'h0;
      step(8, 5'b00001);
      drv.sense_above_exit = 1'h1;
      step(14, 5'b10100);
      $display("reverse done");
      drv.overvoltage = 1'h1;
      step(8, 5'b01010);
      drv.overvoltage = 1'h0;
      step(10, 5'b01010);
      drv.sense_below_enter = 1'h1;
      drv.sense_above_exit = 1'h0;
      step(8, 5'b00011);
      drv.sense_below_enter = 1'h0;
      drv.sense_above_exit = 1'h1;
      step(8, 5'b01010);
      drv.enable = 1'h0;
      step(8, 5'b00000);
      drv.enable = 1'h1;
      step(14, 5'b10100);
      drv.supply_uvlo = 1'h1;
      drv.supply_ok = 1'h0;
      step(8, 5'b00000);
      drv.supply_uvlo = 1'h0;
      step(14, 5'b00000);
      drv.supply_ok = 1'h1;
      step(14, 5'b10100);
      $display("latch and shutdown done");
      finish_test();
   end
endmodule : tb_buck_protection_gate_sequencer
